// >>> hw/iec_regs.svh
/*
  Register offsets, field positions, reset values and mapped-range limits for the
  interconnect error capture block. Assumes inclusion by bare name from hw/.
*/
`ifndef IEC_REGS_SVH
`define IEC_REGS_SVH

// register offsets (byte address, one 32-bit word each); p = port index
`define IEC_STATUS_OFS      8'h00
`define IEC_ENABLE_OFS     8'h04
`define IEC_CTRL_BASE      8'h10
`define IEC_INFO_BASE      8'h30
`define IEC_ADDR_BASE      8'h50

// control register fields
`define IEC_CTRL_LOCK_BIT  0
`define IEC_CTRL_FORCE_BIT 1

// reset values
`define IEC_ENABLE_RST     32'h0000_0000

// crossbar mapped peripheral range, masked writes become full writes there
`define IEC_MAP_LO         32'hF800_0000
`define IEC_MAP_HI         32'hFFFF_FFFF

`endif

// >>> hw/iec_pkg.sv
/*
  Types shared by the interconnect error capture block.
  Assumes the register header is included by the modules that need the offsets.
*/
`default_nettype none

package iec_pkg;

  typedef enum logic [1:0]
  {
    IEC_RMW_IDLE,
    IEC_RMW_READ,
    IEC_RMW_WRITE
  } iec_rmw_e;

  typedef logic [31:0] iec_word_t;

endpackage

`default_nettype wire

// >>> hw/iec_port_capture.sv
/*
  One slave-interface port of the error capture logic: capture registers,
  lock flag, sticky error bit and the notification pulse for that port.
  Assumes error and transaction inputs are synchronous to clk_i.
*/
`timescale 1ns/100ps
`default_nettype none

module iec_port_capture
(
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              txn_valid_i,
  input  wire logic              txn_error_i,
  input  wire logic              txn_secure_i,
  input  wire iec_pkg::iec_word_t txn_addr_i,
  input  wire iec_pkg::iec_word_t txn_info_i,
  input  wire logic              enable_i,
  input  wire logic              force_wr_i,
  input  wire logic              sticky_clr_i,
  input  wire logic              lock_clr_i,
  output logic                   sticky_o,
  output logic                   lock_o,
  output logic                   force_o,
  output logic                   notify_o,
  output iec_pkg::iec_word_t     info_o,
  output iec_pkg::iec_word_t     addr_o
);
  import iec_pkg::*;

  logic err_ev;
  logic cap_ev;
  logic force_q;

  // an errored transaction from the security master never reaches capture
  assign err_ev = txn_valid_i & txn_error_i;
  assign cap_ev = err_ev & ~txn_secure_i & ~lock_o;

  // one-cycle force pulse, only while sticky bit is clear
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      force_q <= 1'b0;
    else
      force_q <= force_wr_i & ~sticky_o;
  end
  assign force_o = force_q;

  // sticky bit: set wins over clear, gated by enable
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sticky_o <= 1'b0;
    else if (err_ev && enable_i)
      sticky_o <= 1'b1;
    else if (sticky_clr_i)
      sticky_o <= 1'b0;
  end

  // lock flag: set by captured error only, not by force
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lock_o <= 1'b0;
    else if (cap_ev)
      lock_o <= 1'b1;
    else if (lock_clr_i)
      lock_o <= 1'b0;
  end

  // address tracks every transaction except a secure errored one while unlocked, frozen while locked
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      addr_o <= 32'h0000_0000;
      info_o <= 32'h0000_0000;
    end
    else if (txn_valid_i && !lock_o && !(txn_error_i && txn_secure_i))
    begin
      addr_o <= txn_addr_i;
      info_o <= txn_info_i;
    end
  end

  // notification on a captured error or a force pulse
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      notify_o <= 1'b0;
    else
      notify_o <= cap_ev | (force_wr_i & ~sticky_o);
  end

endmodule

`default_nettype wire

// >>> hw/iec_top.sv
/*
  Interconnect error capture: per-port protocol error capture, sticky status,
  software-forced notification, and masked read-modify-write handling, with the mask
  ignored (full-word writes) in the crossbar mapped range.
  Assumes a plain register port with read data one cycle after the read strobe,
  and transaction observation inputs synchronous to clk_i.
*/
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

`include "iec_regs.svh"

module iec_top
#(
  parameter int NPORTS = 4
)
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // register port
  input  wire logic [7:0]             reg_addr_i,
  input  wire iec_pkg::iec_word_t     reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output iec_pkg::iec_word_t          reg_rdata_o,
  // observed slave-interface port transactions
  input  wire logic [NPORTS-1:0]      txn_valid_i,
  input  wire logic [NPORTS-1:0]      txn_error_i,
  input  wire logic [NPORTS-1:0]      txn_secure_i,
  input  wire logic [NPORTS*32-1:0]   txn_addr_i,
  input  wire logic [NPORTS*32-1:0]   txn_info_i,
  // notification
  output logic                        alarm_o,
  output logic                        irq_o,
  // masked read-modify-write request from a master
  input  wire logic                   rmw_req_i,
  input  wire iec_pkg::iec_word_t     rmw_addr_i,
  input  wire iec_pkg::iec_word_t     rmw_data_i,
  input  wire iec_pkg::iec_word_t     rmw_mask_i,
  output logic                        rmw_busy_o,
  // crossbar side of the masked access
  output logic                        xbar_lock_o,
  output logic                        xbar_rd_o,
  output logic                        xbar_wr_o,
  output iec_pkg::iec_word_t          xbar_addr_o,
  output iec_pkg::iec_word_t          xbar_wdata_o,
  input  wire iec_pkg::iec_word_t     xbar_rdata_i,
  input  wire logic                   xbar_ack_i
);
  import iec_pkg::*;

  localparam int PW = $clog2(NPORTS) > 0 ? $clog2(NPORTS) : 1;

  logic [NPORTS-1:0] enable_q;
  logic [NPORTS-1:0] sticky;
  logic [NPORTS-1:0] lock;
  logic [NPORTS-1:0] force_p;
  logic [NPORTS-1:0] notify;
  logic [NPORTS-1:0] force_wr;
  logic [NPORTS-1:0] sticky_clr;
  logic [NPORTS-1:0] lock_clr;
  iec_word_t         info  [NPORTS];
  iec_word_t         addr  [NPORTS];

  // per-port decode and capture instance
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++)
    begin : g_port
      localparam logic [7:0] CTRL_A = 8'(`IEC_CTRL_BASE + 4 * g);
      logic ctrl_wr;
      assign ctrl_wr       = reg_wr_i && (reg_addr_i == CTRL_A);
      // each port's own force field
      assign force_wr[g]   = ctrl_wr && reg_wdata_i[`IEC_CTRL_FORCE_BIT];
      assign lock_clr[g]   = ctrl_wr && !reg_wdata_i[`IEC_CTRL_LOCK_BIT];
      // write one to clear the sticky status
      assign sticky_clr[g] = reg_wr_i && (reg_addr_i == `IEC_STATUS_OFS) && reg_wdata_i[g];

      iec_port_capture u_port
      (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .txn_valid_i  (txn_valid_i[g]),
        .txn_error_i  (txn_error_i[g]),
        .txn_secure_i (txn_secure_i[g]),
        .txn_addr_i   (txn_addr_i[g*32 +: 32]),
        .txn_info_i   (txn_info_i[g*32 +: 32]),
        .enable_i     (enable_q[g]),
        .force_wr_i   (force_wr[g]),
        .sticky_clr_i (sticky_clr[g]),
        .lock_clr_i   (lock_clr[g]),
        .sticky_o     (sticky[g]),
        .lock_o       (lock[g]),
        .force_o      (force_p[g]),
        .notify_o     (notify[g]),
        .info_o       (info[g]),
        .addr_o       (addr[g])
      );
    end
  endgenerate

  // enable register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      enable_q <= NPORTS'(`IEC_ENABLE_RST);
    else if (reg_wr_i && reg_addr_i == `IEC_ENABLE_OFS)
      enable_q <= reg_wdata_i[NPORTS-1:0];
  end

  // alarm and interrupt pulse together for any port notification
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      alarm_o <= 1'b0;
      irq_o   <= 1'b0;
    end
    else
    begin
      alarm_o <= |notify;
      irq_o   <= |notify;
    end
  end

  // register read, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
    begin
      reg_rdata_o <= 32'h0000_0000;
      if (reg_addr_i == `IEC_STATUS_OFS)
        reg_rdata_o <= 32'(sticky);
      else if (reg_addr_i == `IEC_ENABLE_OFS)
        reg_rdata_o <= 32'(enable_q);
      else
      begin
        for (int i = 0; i < NPORTS; i++)
        begin
          if (reg_addr_i == 8'(`IEC_CTRL_BASE + 4 * i))
          begin
            reg_rdata_o[`IEC_CTRL_LOCK_BIT]  <= lock[i];
            reg_rdata_o[`IEC_CTRL_FORCE_BIT] <= force_p[i];
          end
          if (reg_addr_i == 8'(`IEC_INFO_BASE + 4 * i))
            reg_rdata_o <= info[i];
          if (reg_addr_i == 8'(`IEC_ADDR_BASE + 4 * i))
            reg_rdata_o <= addr[i];
        end
      end
    end
  end

  // masked read-modify-write sequencer
  iec_rmw_e  rmw_state_q;
  iec_word_t rmw_addr_q;
  iec_word_t rmw_data_q;
  iec_word_t rmw_mask_q;
  logic      in_map;

  assign in_map = (rmw_addr_i >= `IEC_MAP_LO) && (rmw_addr_i <= `IEC_MAP_HI);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rmw_state_q <= IEC_RMW_IDLE;
      rmw_addr_q  <= 32'h0000_0000;
      rmw_data_q  <= 32'h0000_0000;
      rmw_mask_q  <= 32'h0000_0000;
    end
    else
    begin
      unique case (rmw_state_q)
        IEC_RMW_IDLE:
          if (rmw_req_i)
          begin
            rmw_addr_q  <= rmw_addr_i;
            rmw_data_q  <= rmw_data_i;
            // mapped range ignores the mask; peripheral bus keeps it
            rmw_mask_q  <= in_map ? 32'hFFFF_FFFF : rmw_mask_i;
            rmw_state_q <= IEC_RMW_READ;
          end
        IEC_RMW_READ:
          if (xbar_ack_i)
          begin
            rmw_data_q  <= (rmw_data_q & rmw_mask_q) | (xbar_rdata_i & ~rmw_mask_q);
            rmw_state_q <= IEC_RMW_WRITE;
          end
        IEC_RMW_WRITE:
          if (xbar_ack_i)
            rmw_state_q <= IEC_RMW_IDLE;
      endcase
    end
  end

  // lock held from read through write
  assign xbar_lock_o  = (rmw_state_q != IEC_RMW_IDLE);
  assign rmw_busy_o   = xbar_lock_o;
  assign xbar_rd_o    = (rmw_state_q == IEC_RMW_READ);
  assign xbar_wr_o    = (rmw_state_q == IEC_RMW_WRITE);
  assign xbar_addr_o  = rmw_addr_q;
  assign xbar_wdata_o = rmw_data_q;

endmodule

`default_nettype wire

// >>> testbench/iec_top_asserts.sv
/*
  Port-level checker for iec_top: notification timing and masked-access locking.
  Assumes it is bound into every iec_top instance.
*/
`timescale 1ns/100ps
`default_nettype none
module iec_chk
#(
  parameter int NPORTS = 4
)
(
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              reg_wr_i,
  input wire logic [NPORTS-1:0] txn_valid_i,
  input wire logic [NPORTS-1:0] txn_error_i,
  input wire logic [NPORTS-1:0] txn_secure_i,
  input wire logic              alarm_o,
  input wire logic              irq_o,
  input wire logic              rmw_req_i,
  input wire logic              rmw_busy_o,
  input wire logic              xbar_lock_o,
  input wire logic              xbar_rd_o,
  input wire logic              xbar_wr_o,
  input wire logic              xbar_ack_i
);
  // anything that may start a notification: a non-secure error or a register write
  logic cause;
  assign cause = (|(txn_valid_i & txn_error_i & ~txn_secure_i)) | reg_wr_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_pair; alarm_o == irq_o; endproperty
  a_pair: assert property (p_pair) else $error("alarm and irq differ");
  property p_cause;
    alarm_o |-> $past(cause, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("alarm without cause");
  property p_rd_lock; xbar_rd_o |-> xbar_lock_o && !xbar_wr_o; endproperty
  a_rd_lock: assert property (p_rd_lock) else $error("read unlocked");
  property p_wr_lock; xbar_wr_o |-> xbar_lock_o; endproperty
  a_wr_lock: assert property (p_wr_lock) else $error("write unlocked");
  property p_start; rmw_req_i && !rmw_busy_o |=> xbar_lock_o && xbar_rd_o; endproperty
  a_start: assert property (p_start) else $error("request not started");
  property p_hold; xbar_lock_o && !(xbar_wr_o && xbar_ack_i) |=> xbar_lock_o; endproperty
  a_hold: assert property (p_hold) else $error("lock dropped early");
  property p_rd_wr; xbar_rd_o && xbar_ack_i |=> xbar_wr_o && !xbar_rd_o; endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("write not after read");
  property p_end; xbar_wr_o && xbar_ack_i |=> !xbar_lock_o; endproperty
  a_end: assert property (p_end) else $error("lock kept after write");
  property p_busy; rmw_busy_o == xbar_lock_o; endproperty
  a_busy: assert property (p_busy) else $error("busy differs from lock");
  c_alarm: cover property (alarm_o);
  c_done: cover property (xbar_wr_o && xbar_ack_i);
  c_refuse: cover property (rmw_req_i && rmw_busy_o);
endmodule
bind iec_top iec_chk #(.NPORTS(NPORTS)) u_chk (.*);
`default_nettype wire

// >>> testbench/iec_xmodel.sv
/*
  Crossbar slave model for the masked access: one word, prompt or slow ack.
  Assumes read and write requests are held until acknowledged.
*/
`timescale 1ns/100ps
`default_nettype none
module iec_xmodel
#(
  parameter iec_pkg::iec_word_t INIT = 32'h5A5A_A5A5
)
(
  input  wire logic               clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               rd_i,
  input  wire logic               wr_i,
  input  wire logic               slow_i,
  input  wire iec_pkg::iec_word_t wdata_i,
  output iec_pkg::iec_word_t      rdata_o,
  output logic                    ack_o
);
  import iec_pkg::*;
  logic [1:0] wait_q;
  iec_word_t  mem_q;
  assign ack_o = (rd_i | wr_i) && (!slow_i || wait_q == 2'h3);
  // data only valid in the acking read cycle
  assign rdata_o = (rd_i && ack_o) ? mem_q : ~mem_q;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) wait_q <= 2'h0;
    else if (ack_o || !(rd_i | wr_i)) wait_q <= 2'h0;
    else wait_q <= wait_q + 2'h1;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) mem_q <= INIT;
    else if (wr_i && ack_o) mem_q <= wdata_i;
endmodule
`default_nettype wire

// >>> testbench/iec_top_tb.sv
/*
  Self-checking bench for iec_top: masked accesses, then error capture.
  Assumes the crossbar model and the bound checker.
*/
`timescale 1ns/100ps
`default_nettype none
`include "iec_regs.svh"
module iec_top_tb;
  import iec_pkg::*;
  typedef struct {iec_word_t a; iec_word_t d; iec_word_t m; logic s; iec_word_t x;} iec_row_s;
  logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, rmw_req_i, slow, alarm_o, irq_o;
  logic rmw_busy_o, xbar_lock_o, xbar_rd_o, xbar_wr_o, xbar_ack_i;
  logic [7:0] reg_addr_i;
  logic [3:0] txn_valid_i, txn_error_i, txn_secure_i;
  logic [127:0] txn_addr_i, txn_info_i;
  iec_word_t reg_wdata_i, reg_rdata_o, rmw_addr_i, rmw_data_i, rmw_mask_i;
  iec_word_t xbar_addr_o, xbar_wdata_o, xbar_rdata_i, q;
  int mismatches = 0, checks_done = 0, alarms = 0, a, n;
  // address, data, mask, slow slave, expected written word (mapped range writes every bit)
  iec_row_s rows [4] = '{'{32'hF800_0000, 32'h1234_5678, 32'h0000_FFFF, 1'b0, 32'h1234_5678},
    '{32'hFFFF_FFFC, 32'hA5A5_0F0F, 32'h0000_0000, 1'b1, 32'hA5A5_0F0F},
    '{32'hF7FF_FFFC, 32'hFFFF_FFFF, 32'h00FF_0000, 1'b0, 32'hA5FF_0F0F},
    '{32'h0000_0100, 32'h0000_0000, 32'hFFFF_0000, 1'b1, 32'h0000_0F0F}};
  iec_top #(.NPORTS(4)) u_dut (.*);
  iec_xmodel #(.INIT(32'h5A5A_A5A5)) u_xm (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_i(xbar_rd_o),
    .wr_i(xbar_wr_o), .slow_i(slow), .wdata_i(xbar_wdata_o), .rdata_o(xbar_rdata_i), .ack_o(xbar_ack_i));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (alarm_o === 1'b1) alarms++;
  task automatic cmp(input string nm, input iec_word_t ex, input iec_word_t got);
    checks_done++;
    if (got !== ex)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
      mismatches++;
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ad, input iec_word_t d);
    @(posedge clk_i);
    reg_addr_i <= ad; reg_wdata_i <= d; reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk_i);
    reg_addr_i <= ad; reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 q = reg_rdata_o;
  endtask
  task automatic tx(input int p, input logic er, input logic sc, input iec_word_t ad);
    @(posedge clk_i);
    txn_valid_i <= 4'h1 << p; txn_error_i <= {4{er}}; txn_secure_i <= {4{sc}};
    txn_addr_i[p*32+:32] <= ad; txn_info_i[p*32+:32] <= ~ad;
    @(posedge clk_i);
    txn_valid_i <= 4'h0;
    repeat (3) @(posedge clk_i);
  endtask
  initial
  begin
    {rst_n_i, reg_wr_i, reg_rd_i, rmw_req_i, slow, reg_addr_i, reg_wdata_i} = '0;
    {txn_valid_i, txn_error_i, txn_secure_i, txn_addr_i, txn_info_i} = '0;
    {rmw_addr_i, rmw_data_i, rmw_mask_i} = '0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (rows[i])
    begin
      @(posedge clk_i);
      slow <= rows[i].s;
      rmw_req_i <= 1'b1;
      rmw_addr_i <= rows[i].a;
      rmw_data_i <= rows[i].d;
      rmw_mask_i <= rows[i].m;
      @(posedge clk_i);
      // data must have been taken with the request
      rmw_data_i <= ~rows[i].d;
      @(posedge clk_i);
      rmw_req_i <= 1'b0;
      for (n = 0; n < 40; n++)
      begin
        #1;
        if (xbar_wr_o === 1'b1 && xbar_ack_i === 1'b1)
          break;
        @(posedge clk_i);
      end
      if (n == 40)
      begin
        mismatches++;
        final_report();
      end
      cmp("rmw wdata", rows[i].x, xbar_wdata_o);
      cmp("rmw addr", rows[i].a, xbar_addr_o);
      @(posedge clk_i);
      #1;
      cmp("lock free", 32'h0, {31'h0, xbar_lock_o});
    end
    rd(`IEC_STATUS_OFS);
    cmp("status rst", 32'h0, q);
    rd(`IEC_ENABLE_OFS);
    cmp("enable rst", `IEC_ENABLE_RST, q);
    wr(`IEC_ENABLE_OFS, 32'h3);
    tx(0, 1'b0, 1'b0, 32'h0000_1000);
    rd(`IEC_ADDR_BASE);
    cmp("addr track", 32'h0000_1000, q);
    a = alarms;
    tx(0, 1'b1, 1'b0, 32'h0000_2000);
    cmp("err alarm", a + 1, alarms);
    rd(`IEC_STATUS_OFS);
    cmp("sticky0", 32'h1, q);
    rd(`IEC_CTRL_BASE);
    cmp("lock0", 32'h1, q & 32'h1);
    rd(`IEC_INFO_BASE);
    cmp("info0", ~32'h0000_2000, q);
    tx(0, 1'b1, 1'b0, 32'h0000_3000);
    rd(`IEC_ADDR_BASE);
    cmp("addr frozen", 32'h0000_2000, q);
    cmp("locked quiet", a + 1, alarms);
    tx(1, 1'b1, 1'b1, 32'h0000_4000);
    tx(2, 1'b1, 1'b0, 32'h0000_5000);
    rd(`IEC_STATUS_OFS);
    cmp("sticky secure", 32'h3, q);
    rd(`IEC_ADDR_BASE + 8'h04);
    cmp("secure uncapt", 32'h0, q);
    rd(`IEC_CTRL_BASE + 8'h04);
    cmp("secure nolock", 32'h0, q);
    // idle transaction fields on port 3, so a capture on force would show
    txn_addr_i[127:96] <= 32'h0000_7000;
    txn_info_i[127:96] <= 32'h0000_7001;
    a = alarms;
    wr(`IEC_CTRL_BASE + 8'h0C, 32'h2);
    cmp("force alarm", a + 1, alarms);
    rd(`IEC_CTRL_BASE + 8'h0C);
    cmp("force nolock", 32'h0, q);
    rd(`IEC_ADDR_BASE + 8'h0C);
    cmp("force nocapt", 32'h0, q);
    rd(`IEC_INFO_BASE + 8'h0C);
    cmp("force noinfo", 32'h0, q);
    wr(`IEC_CTRL_BASE, 32'h2);
    cmp("force sticky", a + 1, alarms);
    wr(`IEC_STATUS_OFS, 32'h1);
    wr(`IEC_CTRL_BASE, 32'h0);
    tx(0, 1'b0, 1'b0, 32'h0000_6000);
    rd(`IEC_ADDR_BASE);
    cmp("unlock track", 32'h0000_6000, q);
    wr(`IEC_CTRL_BASE, 32'h2);
    cmp("force clear", a + 2, alarms);
    // force write then read with no gap: the force bit stands only in the next cycle
    @(posedge clk_i);
    reg_addr_i <= `IEC_CTRL_BASE + 8'h0C;
    reg_wdata_i <= 32'h2;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    q = reg_rdata_o;
    cmp("force pulse", 32'h2, q);
    rd(`IEC_CTRL_BASE + 8'h0C);
    cmp("force self clr", 32'h0, q);
    // second reset in mid-run clears sticky, enable, lock and capture
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(`IEC_STATUS_OFS);
    cmp("status rerst", 32'h0, q);
    rd(`IEC_ENABLE_OFS);
    cmp("enable rerst", `IEC_ENABLE_RST, q);
    rd(`IEC_CTRL_BASE + 8'h08);
    cmp("lock rerst", 32'h0, q);
    rd(`IEC_ADDR_BASE + 8'h08);
    cmp("addr rerst", 32'h0, q);
    final_report();
  end
endmodule
`default_nettype wire
